//--- src/bsc_boundary_chain.sv
// Behaviour
// - chain sits between tdi and tdo only under sample, external or internal test
// - clamp instructions take pin data from chain and leave its contents alone; clamp drives the pins, clamp-float floats them
// - normal mode passes core and pad signals straight through
// - test modes apply update values to core inputs and output pins
// - every cell has its own parallel update latch
// - extra cells in the chain drive tristate bus enables
// - order from tdi: D23 in, D23 out, pairs down, data enable at 30, address enable at 45
// - every input cell can drive a test value into the core
// - chain contents are lost on test reset; tester reloads them
// - data-bus enable cell: stored 1 floats the drivers
// - address-bus enable cell: stored 0 floats the drivers
// - core-driven disable is captured as 1 in the data-bus enable cell
// - internal test single-steps: update applies, capture samples outputs
// - state holds with tck stopped in either phase
// - tdo driver enabled only in shift-dr or shift-ir
// - cells capture pad and core signals on rising tck in capture-dr
// - code 0011 is sample; its update is not applied to pins
// - code 1100 is internal test, all cells in test mode
// - code 0111 floats every output
`timescale 1ns/100ps

`include "bsc_params.svh"

module bsc_boundary_chain (
  // core clock
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // tap side, link clock
  input  wire logic                  tck,
  input  wire bsc_pkg::bsc_tap_s     tap,
  input  wire logic [3:0]            instr,
  input  wire logic                  tdi,
  // serial output
  output logic                       tdo,
  output logic                       tdo_oe,
  output logic                       chain_sel,
  // core side
  input  wire bsc_pkg::bsc_core_s    core,
  output logic [`BSC_DBITS-1:0]      core_d_in,
  // pads
  input  wire logic [`BSC_DBITS-1:0] pad_d_in,
  output logic [`BSC_DBITS-1:0]      pad_d_out,
  output logic [`BSC_DBITS-1:0]      pad_d_oe,
  output logic                       addr_oe
);

  // ========================================================
  // decoding
  function automatic bsc_pkg::bsc_mode_e decode(input logic [3:0] op);
    case (op)
      `BSC_OP_SAMPLE:      decode = bsc_pkg::mode_sample;
      `BSC_OP_EXTEST:      decode = bsc_pkg::mode_extest;
      `BSC_OP_INTEST:      decode = bsc_pkg::mode_intest;
      `BSC_OP_CLAMP:       decode = bsc_pkg::mode_clamp;
      `BSC_OP_CLAMP_FLOAT: decode = bsc_pkg::mode_clamp_float;
      `BSC_OP_HIGHZ:       decode = bsc_pkg::mode_highz;
      default:             decode = bsc_pkg::mode_normal;
    endcase
  endfunction

  function automatic logic is_test(input bsc_pkg::bsc_mode_e m);
    is_test = (m == bsc_pkg::mode_extest) || (m == bsc_pkg::mode_intest);
  endfunction

  // data bit index of a data cell, D[23] is index 21
  function automatic int cell_bit(input int i);
    if (i < `BSC_EN_DATA) begin
      cell_bit = `BSC_DATA_TOP - i / 2;
    end else begin
      cell_bit = `BSC_DATA_MID - (i - `BSC_EN_DATA - 1) / 2;
    end
  endfunction

  function automatic logic cell_is_in(input int i);
    if (i < `BSC_EN_DATA) begin
      cell_is_in = (i % 2) == 0;
    end else begin
      cell_is_in = ((i - `BSC_EN_DATA - 1) % 2) == 0;
    end
  endfunction

  // ========================================================
  // link domain: sources and mode
  typedef struct packed {
    bsc_pkg::bsc_pub_s pub;
    logic              tgl;
  } bsc_tck_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bsc_fall_s;

  logic [`BSC_DBITS-1:0]     pad_t;
  bsc_pkg::bsc_core_s        core_t;
  bsc_pkg::bsc_mode_e        mode_t;
  logic [`BSC_CHAIN_LEN-1:0] cap_vec;
  bsc_pkg::bsc_chain_s       chain;
  bsc_pkg::bsc_pub_s         word_t;
  bsc_tck_s                  t;
  bsc_tck_s                  next_t;
  bsc_fall_s                 f;
  bsc_fall_s                 next_f;

  bsc_sync #(
    .W ($bits(pad_d_in) + $bits(core))
  ) u_sync_tck (
    .clk (tck),
    .rst (tap.test_reset),
    .d   ({pad_d_in, core}),
    .q   ({pad_t, core_t})
  );

  assign mode_t = decode(instr);

  // only these three instructions put the chain on the serial path
  assign chain_sel = (mode_t == bsc_pkg::mode_sample) ||
                     is_test(mode_t);

  // ========================================================
  // capture sources per cell
  genvar g;
  generate
    for (g = 0; g < `BSC_CHAIN_LEN; g = g + 1) begin : g_cap
      localparam int B = cell_bit(g);
      if (g == `BSC_EN_DATA) begin : g_en_one
        // core disabling the drivers shows as 1
        assign cap_vec[g] = core_t.d_oe_n;
      end else if (g == `BSC_EN_ADDR) begin : g_en_zero
        assign cap_vec[g] = core_t.a_oe;
      end else if (cell_is_in(g)) begin : g_in
        // internal test reads back the complement of the core input
        assign cap_vec[g] = (mode_t == bsc_pkg::mode_intest) ?
                            ~chain.upd[g] : pad_t[B];
      end else begin : g_out
        assign cap_vec[g] = core_t.d_out[B];
      end
    end
  endgenerate

  // ========================================================
  // chain cells
  bsc_scan_cells u_cells (
    .tck     (tck),
    .reset   (tap.test_reset),
    .capture (tap.capture_dr && chain_sel),
    .shift   (tap.shift_dr && chain_sel),
    .update  (tap.update_dr && chain_sel),
    .tdi     (tdi),
    .cap_vec (cap_vec),
    .chain   (chain)
  );

  // ========================================================
  // publish mode and latches to the core domain
  always_comb begin
    word_t.mode = mode_t;
    word_t.upd  = chain.upd;
  end

  always_comb begin
    next_t = t;
    if (tap.test_reset) begin
      next_t = '0;
    end else if (word_t != t.pub) begin
      next_t.pub = word_t;
      next_t.tgl = ~t.tgl;
    end
  end

  always_ff @(posedge tck) begin
    t <= next_t;
  end

  // ========================================================
  // serial output changes on the falling edge
  always_comb begin
    next_f.tdo    = chain.sr[`BSC_CHAIN_LEN-1];
    next_f.tdo_oe = tap.shift_dr || tap.shift_ir;
    if (tap.test_reset) begin
      next_f = '0;
    end
  end

  always_ff @(negedge tck) begin
    f <= next_f;
  end

  assign tdo    = f.tdo;
  assign tdo_oe = f.tdo_oe;

  // ========================================================
  // core domain
  typedef struct packed {
    logic                  seen;
    bsc_pkg::bsc_pub_s     pub;
    logic [`BSC_DBITS-1:0] din;
    logic [`BSC_DBITS-1:0] dout;
    logic                  d_en;
    logic                  a_en;
  } bsc_clk_s;

  logic                  tgl_c;
  logic [`BSC_DBITS-1:0] pad_c;
  logic [`BSC_DBITS-1:0] lat_din;
  logic [`BSC_DBITS-1:0] lat_dout;
  logic                  lat_en_one;
  logic                  lat_en_zero;
  logic                  test_c;
  logic                  drive_c;
  logic                  float_c;
  bsc_clk_s              c;
  bsc_clk_s              next_c;

  bsc_sync #(
    .W (1)
  ) u_sync_tgl (
    .clk (clk),
    .rst (rst),
    .d   (t.tgl),
    .q   (tgl_c)
  );

  bsc_sync #(
    .W (`BSC_DBITS)
  ) u_sync_pad (
    .clk (clk),
    .rst (rst),
    .d   (pad_d_in),
    .q   (pad_c)
  );

  generate
    for (g = 0; g < `BSC_CHAIN_LEN; g = g + 1) begin : g_lat
      localparam int B = cell_bit(g);
      if (g != `BSC_EN_DATA && g != `BSC_EN_ADDR) begin : g_data
        if (cell_is_in(g)) begin : g_in
          assign lat_din[B] = c.pub.upd[g];
        end else begin : g_out
          assign lat_dout[B] = c.pub.upd[g];
        end
      end
    end
  endgenerate

  assign lat_en_one  = c.pub.upd[`BSC_EN_DATA];
  assign lat_en_zero = c.pub.upd[`BSC_EN_ADDR];
  assign test_c      = is_test(c.pub.mode);
  assign drive_c     = test_c || (c.pub.mode == bsc_pkg::mode_clamp);
  assign float_c     = (c.pub.mode == bsc_pkg::mode_highz) ||
                       (c.pub.mode == bsc_pkg::mode_clamp_float);

  always_comb begin
    next_c = c;
    if (rst) begin
      next_c = '0;
    end else if (ce) begin
      // copy taken once the toggle has settled, word is then stable
      if (tgl_c != c.seen) begin
        next_c.seen = tgl_c;
        next_c.pub  = t.pub;
      end
      // core inputs: latched test values or straight from the pads
      next_c.din = test_c ? lat_din : pad_c;
      // pin data: latches under test and both clamps
      next_c.dout = (drive_c || c.pub.mode == bsc_pkg::mode_clamp_float) ?
                    lat_dout : core.d_out;
      if (drive_c) begin
        next_c.d_en = ~lat_en_one;
        next_c.a_en = lat_en_zero;
      end else if (float_c) begin
        next_c.d_en = 1'b0;
        next_c.a_en = 1'b0;
      end else begin
        next_c.d_en = ~core.d_oe_n;
        next_c.a_en = core.a_oe;
      end
    end
  end

  always_ff @(posedge clk) begin
    c <= next_c;
  end

  assign core_d_in = c.din;
  assign pad_d_out = c.dout;
  assign pad_d_oe  = {`BSC_DBITS{c.d_en}};
  assign addr_oe   = c.a_en;

  // ========================================================
  // checks
  a_normal_pass: assert property (
    @(posedge clk) disable iff (rst)
    (ce && c.pub.mode == bsc_pkg::mode_normal) |=>
      (pad_d_out == $past(core.d_out)) && (core_d_in == $past(pad_c)))
    else $error("normal mode does not pass signals through");

  a_highz_float: assert property (
    @(posedge clk) disable iff (rst)
    (ce && c.pub.mode == bsc_pkg::mode_highz) |=>
      (!addr_oe && pad_d_oe == '0))
    else $error("high-z mode left a driver on");

  a_test_core: assert property (
    @(posedge clk) disable iff (rst)
    (ce && test_c) |=> (core_d_in == $past(lat_din)))
    else $error("test mode core inputs not from latches");

  a_en_one_float: assert property (
    @(posedge clk) disable iff (rst)
    (ce && drive_c && lat_en_one) |=> (pad_d_oe == '0))
    else $error("stored 1 did not float data bus");

  a_en_zero_float: assert property (
    @(posedge clk) disable iff (rst)
    (ce && drive_c && !lat_en_zero) |=> !addr_oe)
    else $error("stored 0 did not float address bus");

  a_clamp_hold: assert property (
    @(posedge tck) disable iff (tap.test_reset)
    !chain_sel |=> $stable(chain))
    else $error("chain changed while not selected");

  a_shift_entry: assert property (
    @(posedge tck) disable iff (tap.test_reset)
    (tap.shift_dr && chain_sel && !tap.capture_dr) |=>
      (chain.sr[0] == $past(tdi)) && (chain.sr[1] == $past(chain.sr[0])))
    else $error("shift path out of order");

  a_capture_out: assert property (
    @(posedge tck) disable iff (tap.test_reset)
    (tap.capture_dr && chain_sel) |=>
      (chain.sr[1] == $past(core_t.d_out[`BSC_DATA_TOP])) &&
      (chain.sr[`BSC_EN_DATA] == $past(core_t.d_oe_n)))
    else $error("capture missed core outputs");

  a_intest_cmpl: assert property (
    @(posedge tck) disable iff (tap.test_reset)
    (tap.capture_dr && mode_t == bsc_pkg::mode_intest) |=>
      (chain.sr[0] == !$past(chain.upd[0])))
    else $error("internal test capture not complemented");

  a_tdo_enable: assert property (
    @(negedge tck) disable iff (tap.test_reset)
    1'b1 |=> (tdo_oe == $past(tap.shift_dr || tap.shift_ir)))
    else $error("tdo enable does not follow shift states");

endmodule

//--- src/bsc_params.svh
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ==========================================================
// instruction codes
`define BSC_OP_EXTEST      4'h0
`define BSC_OP_SAMPLE      4'h3
`define BSC_OP_CLAMP       4'h5
`define BSC_OP_HIGHZ       4'h7
`define BSC_OP_CLAMP_FLOAT 4'h9
`define BSC_OP_INTEST      4'hC

// ==========================================================
// chain layout, index 0 is the cell nearest the serial input
`define BSC_CHAIN_LEN      46
`define BSC_DBITS          22
`define BSC_EN_DATA        30
`define BSC_EN_ADDR        45
`define BSC_DATA_TOP       21
`define BSC_DATA_MID       6

// ==========================================================
// reset values
`define BSC_RST_BIT        1'h0

`endif

//--- src/bsc_pkg.sv
package bsc_pkg;

`include "bsc_params.svh"

  // ========================================================
  // modes
  typedef enum logic [2:0] {
    mode_normal,
    mode_sample,
    mode_extest,
    mode_intest,
    mode_clamp,
    mode_clamp_float,
    mode_highz
  } bsc_mode_e;

  // ========================================================
  // carriers
  typedef struct packed {
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic shift_ir;
    logic test_reset;
  } bsc_tap_s;

  typedef struct packed {
    logic [`BSC_DBITS-1:0] d_out;
    logic                  d_oe_n;
    logic                  a_oe;
  } bsc_core_s;

  typedef struct packed {
    logic [`BSC_CHAIN_LEN-1:0] sr;
    logic [`BSC_CHAIN_LEN-1:0] upd;
  } bsc_chain_s;

  typedef struct packed {
    bsc_mode_e                 mode;
    logic [`BSC_CHAIN_LEN-1:0] upd;
  } bsc_pub_s;

endpackage

//--- src/bsc_scan_cells.sv
`timescale 1ns/100ps

`include "bsc_params.svh"

module bsc_scan_cells (
  // link clock and reset
  input  wire logic                      tck,
  input  wire logic                      reset,
  // cell controls
  input  wire logic                      capture,
  input  wire logic                      shift,
  input  wire logic                      update,
  input  wire logic                      tdi,
  input  wire logic [`BSC_CHAIN_LEN-1:0] cap_vec,
  // state
  output bsc_pkg::bsc_chain_s            chain
);

  bsc_pkg::bsc_chain_s st;
  bsc_pkg::bsc_chain_s next_st;

  always_comb begin
    next_st = st;
    if (reset) begin
      next_st = '0;
    end else begin
      if (capture) begin
        next_st.sr = cap_vec;
      end else if (shift) begin
        next_st.sr = {st.sr[`BSC_CHAIN_LEN-2:0], tdi};
      end
      // every cell has its own parallel update latch
      if (update) begin
        next_st.upd = st.sr;
      end
    end
  end

  // plain edge flops: no refresh, tck may stop in either phase
  always_ff @(posedge tck) begin
    st <= next_st;
  end

  assign chain = st;

endmodule

//--- src/bsc_sync.sv
`timescale 1ns/100ps

`include "bsc_params.svh"

module bsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsc_sync_s;

  bsc_sync_s st;
  bsc_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    if (rst) begin
      next_st = {2 * W{`BSC_RST_BIT}};
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.s2;

endmodule

//--- verification/bsc_tester.sv
`timescale 1ns/100ps

module bsc_tester (
  // tap drive
  output logic              tck,
  output bsc_pkg::bsc_tap_s tap,
  output logic [3:0]        instr,
  output logic              tdi,
  // serial return
  input  wire logic         tdo,
  input  wire logic         tdo_oe
);
  // ====
  // idle: tck stands low between frames
  initial begin
    tck   = 1'h0;
    tap   = '0;
    instr = 4'hF;
    tdi   = 1'h0;
  end

  // one tck cycle; signals move 7 ns after each fall
  task automatic pulse(input int hi);
    #8 tck = 1'h1;
    #(hi) tck = 1'h0;
    #7;
  endtask

  // tms taken as held high while reset lets go
  task automatic treset();
    tap            = '0;
    tap.test_reset = 1'h1;
    repeat (3) pulse(15);
    tap = '0;
    pulse(15);
  endtask

  task automatic set_ir(input logic [3:0] code);
    instr = code;
    repeat (3) pulse(15);
  endtask

  // capture, shift v in from bit 45 down, update
  task automatic scan(input logic [45:0] v, output logic [45:0] q,
                      output logic oe);
    tap            = '0;
    tap.capture_dr = 1'h1;
    pulse(15);
    tap          = '0;
    tap.shift_dr = 1'h1;
    oe           = 1'h1;
    for (int k = 45; k >= 0; k--) begin
      tdi  = v[k];
      q[k] = tdo;
      oe   = oe & (k == 45 || tdo_oe === 1'h1);
      pulse(k == 20 ? 1000 : 15);
    end
    tap           = '0;
    tap.update_dr = 1'h1;
    tdi           = ~tdi;
    pulse(15);
    tap = '0;
    pulse(15);
  endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  // ====
  // signals
  logic               clk, rst, ce, tck, tdi, tdo, tdo_oe;
  logic               chain_sel, addr_oe;
  logic [3:0]         instr;
  logic [21:0]        core_d_in, pad_d_in, pad_d_out, pad_d_oe;
  logic [45:0]        v, w, u;
  logic [66:0]        e;
  logic [31:0]        seed;
  int                 n_mismatch, n_compared;
  bsc_pkg::bsc_tap_s  tap;
  bsc_pkg::bsc_core_s core;

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ====
  // design and tester
  bsc_boundary_chain i_dut (
    .clk(clk), .rst(rst), .ce(ce), .tck(tck), .tap(tap),
    .instr(instr), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .chain_sel(chain_sel), .core(core), .core_d_in(core_d_in),
    .pad_d_in(pad_d_in), .pad_d_out(pad_d_out),
    .pad_d_oe(pad_d_oe), .addr_oe(addr_oe)
  );

  bsc_tester i_tst (
    .tck(tck), .tap(tap), .instr(instr), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe)
  );

  // ====
  // expectations
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic odd(int i);
    return (i < 30) ? i[0] : !i[0];
  endfunction

  function automatic int bix(int i);
    return (i < 30) ? 21 - i / 2 : 6 - (i - 31) / 2;
  endfunction

  function automatic logic [45:0] cells(logic [21:0] din,
                                        logic [21:0] dout,
                                        logic ed, logic ea);
    logic [45:0] r;
    r = '0;
    for (int i = 0; i < 45; i++) begin
      r[i] = odd(i) ? dout[bix(i)] : din[bix(i)];
    end
    r[30] = ed;
    r[45] = ea;
    return r;
  endfunction

  function automatic logic [21:0] part(logic [45:0] c, logic o);
    logic [21:0] r;
    r = '0;
    for (int i = 0; i < 45; i++) begin
      if (i != 30 && odd(i) == o) begin
        r[bix(i)] = c[i];
      end
    end
    return r;
  endfunction

  function automatic logic [66:0] pins();
    return {core_d_in, pad_d_out, pad_d_oe, addr_oe};
  endfunction

  function automatic logic [66:0] thru();
    return {pad_d_in, core.d_out, {22{~core.d_oe_n}}, core.a_oe};
  endfunction

  function automatic logic [66:0] held(logic [45:0] c);
    return {part(c, 1'h0), part(c, 1'h1), {22{~c[30]}}, c[45]};
  endfunction

  function automatic logic [45:0] snap();
    return cells(pad_d_in, core.d_out, core.d_oe_n, core.a_oe);
  endfunction

  // ====
  // tasks
  task automatic chk(input logic [66:0] g, input logic [66:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask

  task automatic drive();
    @(negedge clk);
    core     = 24'(rnd());
    pad_d_in = 22'(rnd());
  endtask

  task automatic settle();
    repeat (10) @(negedge clk);
  endtask

  task automatic tscan(input logic [45:0] c, input logic [45:0] x);
    logic [45:0] q;
    logic        oe;
    i_tst.scan(c, q, oe);
    chk(q, x);
    chk({oe, tdo_oe}, 2'h2);
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ====
  // sequence
  initial begin
    seed       = 32'hBBC4C8C0;
    n_mismatch = 0;
    n_compared = 0;
    rst        = 1'h1;
    ce         = 1'h1;
    core       = '0;
    pad_d_in   = '0;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    i_tst.treset();
    for (int k = 0; k < 4; k++) begin
      drive();
      settle();
      chk(pins(), thru());
    end
    for (int k = 0; k < 16; k++) begin
      i_tst.set_ir(4'(k));
      chk(chain_sel, k == 0 || k == 3 || k == 12);
    end
    // preload, then external or internal test, both enable values
    for (int k = 0; k < 4; k++) begin
      v     = 46'({rnd(), rnd()});
      v[30] = k[0];
      v[45] = k[0];
      drive();
      i_tst.set_ir(4'h3);
      tscan(v, snap());
      settle();
      chk(pins(), thru());
      drive();
      i_tst.set_ir(k[1] ? 4'hC : 4'h0);
      settle();
      chk(pins(), held(v));
      w = 46'({rnd(), rnd()});
      u = k[1] ? cells(~part(v, 1'h0), core.d_out, core.d_oe_n,
                       core.a_oe) : snap();
      tscan(w, u);
      settle();
      chk(pins(), held(w));
    end
    // clamp keeps the chain and drives pins from it
    e = held(w);
    drive();
    i_tst.set_ir(4'h5);
    settle();
    chk(pins(), {pad_d_in, e[44:0]});
    tscan(~w, {46{w[45]}});
    settle();
    chk(pins(), {pad_d_in, e[44:0]});
    i_tst.set_ir(4'h9);
    settle();
    chk({pad_d_out, pad_d_oe, addr_oe}, {e[44:23], 23'h0});
    i_tst.set_ir(4'h7);
    settle();
    chk({pad_d_out, pad_d_oe, addr_oe}, {core.d_out, 23'h0});
    i_tst.treset();
    i_tst.set_ir(4'h0);
    settle();
    chk(pins(), held(46'h0));
    results();
  end
endmodule
